/* File: rtl/fssd_top.sv */
// fieldbus station switch decoder with apb readback
`timescale 1ns/1ps
`include "fssd_cfg.svh"
module fssd_top
  import fssd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] address_low_switch_bank,
  input wire logic [3:0] link_config_switch_bank,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rate_hi,
  output logic [5:0] payload_len,
  output logic [7:0] station_addr,
  output logic addr_valid,
  output logic cfg_ready
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pins;
  logic [7:0] pins_s;
  assign pins = {link_config_switch_bank, address_low_switch_bank};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      fssd_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pins[gi]),
        .dout(pins_s[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // latch sequence
  // ----------------------------------------------------------------
  // wait three edges so the synchronisers hold real pin levels, not reset zeros
  fssd_state_t state_q;
  fssd_state_t state_d;
  logic [1:0] wait_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      FSSD_WAIT: begin
        if (wait_q == 2'h2) begin
          state_d = FSSD_LATCH;
        end
      end
      FSSD_LATCH: state_d = FSSD_RUN;
      FSSD_RUN: state_d = FSSD_RUN;
      default: state_d = FSSD_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FSSD_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
    end else if (state_q == FSSD_WAIT) begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // switch snapshot and decode
  // ----------------------------------------------------------------
  logic [3:0] addr_sw_q;
  logic [3:0] cfg_sw_q;

  // captured once per reset, later pin moves are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_sw_q <= 4'h0;
      cfg_sw_q <= 4'h0;
    end else if (state_q == FSSD_LATCH) begin
      addr_sw_q <= pins_s[3:0];
      cfg_sw_q <= pins_s[7:4];
    end
  end

  fssd_link_cfg_t dec;
  always_comb begin
    dec.rate_hi = cfg_sw_q[`FSSD_CFG_RATE_POS];
    // length position is ignored at the legacy rate
    dec.payload_len = (cfg_sw_q[`FSSD_CFG_RATE_POS] && cfg_sw_q[`FSSD_CFG_LEN_POS]) ?
      `FSSD_LEN_LONG : `FSSD_LEN_SHORT;
    // bank weights are plain binary, so the value adds straight on
    dec.station_addr = (cfg_sw_q[`FSSD_CFG_BASE_POS] ? `FSSD_ADDR_BASE_HI : `FSSD_ADDR_BASE_LO) +
      {4'h0, addr_sw_q};
    // only 40h is disabled; 50h is a usable address
    dec.addr_valid = cfg_sw_q[`FSSD_CFG_BASE_POS] || (addr_sw_q != 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_hi <= 1'b0;
      payload_len <= `FSSD_LEN_SHORT;
      station_addr <= `FSSD_ADDR_BASE_LO;
      addr_valid <= 1'b0;
      cfg_ready <= 1'b0;
    end else begin
      rate_hi <= dec.rate_hi;
      payload_len <= dec.payload_len;
      station_addr <= dec.station_addr;
      addr_valid <= dec.addr_valid;
      cfg_ready <= (state_q == FSSD_RUN);
    end
  end

  // ----------------------------------------------------------------
  // apb read-only status
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  logic hit;
  always_comb begin
    rdata_d = 32'h0;
    hit = 1'b1;
    case (paddr)
      `FSSD_OFF_ADDR: rdata_d = {23'h0, addr_valid, station_addr};
      `FSSD_OFF_CFG: rdata_d = {24'h0, cfg_ready, rate_hi, payload_len};
      `FSSD_OFF_RAW: rdata_d = {24'h0, cfg_sw_q, addr_sw_q};
      // live pins let software see a pending change that needs a restart
      `FSSD_OFF_LIVE: rdata_d = {24'h0, pins_s};
      default: hit = 1'b0;
    endcase
  end

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !hit || pwrite;
      prdata <= (hit && !pwrite) ? rdata_d : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready && $past(cfg_ready) |-> $stable(station_addr) && $stable(payload_len) && $stable(rate_hi))
    else $error("configuration changed while running");
  rate_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready |-> rate_hi == cfg_sw_q[0])
    else $error("rate does not follow bank position");
  len_legacy_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready && !rate_hi |-> payload_len == 6'h11)
    else $error("legacy rate payload not 17");
  len_long_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready && cfg_sw_q[1:0] == 2'b11 |-> payload_len == 6'h20)
    else $error("long payload not selected");
  addr_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready |-> station_addr == (cfg_sw_q[2] ? 8'h50 : 8'h40) + {4'h0, addr_sw_q})
    else $error("station address sum wrong");
  addr_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready |-> addr_valid == (station_addr != 8'h40))
    else $error("address valid flag wrong");
  factory_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ready && !cfg_sw_q[2] && addr_sw_q == 4'h1 |-> station_addr == 8'h41 && addr_valid)
    else $error("shipped setting not address 41h");
  latch_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cfg_ready) |-> $past(state_q, 2) == FSSD_LATCH)
    else $error("ready not two edges after latch");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule

/* File: rtl/fssd_cfg.svh */
// constants for the fieldbus station switch decoder
`ifndef FSSD_CFG_SVH
`define FSSD_CFG_SVH
`define FSSD_CFG_RATE_POS 0
`define FSSD_CFG_LEN_POS 1
`define FSSD_CFG_BASE_POS 2
`define FSSD_CFG_RSVD_POS 3
`define FSSD_ADDR_BASE_LO 8'h40
`define FSSD_ADDR_BASE_HI 8'h50
`define FSSD_LEN_SHORT 6'h11
`define FSSD_LEN_LONG 6'h20
`define FSSD_RATE_LEGACY_MBPS 4
`define FSSD_RATE_CURRENT_MBPS 10
`define FSSD_OFF_ADDR 8'h00
`define FSSD_OFF_CFG 8'h04
`define FSSD_OFF_RAW 8'h08
`define FSSD_OFF_LIVE 8'h0c
`endif

/* File: rtl/fssd_pkg.sv */
// types for the fieldbus station switch decoder
package fssd_pkg;
  typedef enum logic [1:0] {
    FSSD_WAIT = 2'b00,
    FSSD_LATCH = 2'b01,
    FSSD_RUN = 2'b10
  } fssd_state_t;

  typedef struct packed {
    logic rate_hi;
    logic [5:0] payload_len;
    logic [7:0] station_addr;
    logic addr_valid;
  } fssd_link_cfg_t;
endpackage

/* File: rtl/fssd_sync.sv */
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module fssd_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: tb/fssd_switch_model.sv */
// installer-set switch banks facing the decoder
`timescale 1ns/1ps
module fssd_switch_model (
  input wire logic [3:0] addr_set,
  input wire logic base_hi,
  input wire logic rate_on,
  input wire logic len_on,
  input wire logic legacy_net,
  output logic [3:0] address_low_switch_bank,
  output logic [3:0] link_config_switch_bank
);
  assign address_low_switch_bank = addr_set;
  // reserved position stays off
  // on a legacy network the installer turns rate and length both off
  // elsewhere both positions pass as set, so the ignored length bit is exercised
  assign link_config_switch_bank = {1'h0, base_hi, len_on & !legacy_net, rate_on & !legacy_net};
endmodule

/* File: tb/fieldbus_station_switch_decode_bench.sv */
// self-checking bench for the station switch decoder
`timescale 1ns/1ps
module fieldbus_station_switch_decode_bench;
  logic pclk, presetn, psel, penable, pwrite, base_hi, rate_on, len_on, legacy_net, err;
  logic [3:0] addr_set, sw_a, sw_c;
  logic [7:0] paddr, station_addr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rate_hi, addr_valid, cfg_ready;
  logic [5:0] payload_len;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  fssd_switch_model fssd_switch_model_inst (.addr_set(addr_set), .base_hi(base_hi), .rate_on(rate_on),
    .len_on(len_on), .legacy_net(legacy_net), .address_low_switch_bank(sw_a), .link_config_switch_bank(sw_c));
  fssd_top fssd_top_inst (.pclk(pclk), .presetn(presetn), .address_low_switch_bank(sw_a),
    .link_config_switch_bank(sw_c), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rate_hi(rate_hi),
    .payload_len(payload_len), .station_addr(station_addr), .addr_valid(addr_valid), .cfg_ready(cfg_ready));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pready is a one-cycle pulse: sampled and taken at the rising edge where it stands high
  task automatic apb(logic wr, logic [7:0] a);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    cmp("apb answer", 32'h1, {31'h0, pready});
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge so a following call never re-drives psel in the same step
    @(posedge pclk);
  endtask

  task automatic restart(logic [3:0] a, logic b, logic r, logic l);
    int n;
    n = 0;
    presetn <= 1'h0;
    addr_set <= a;
    base_hi <= b;
    rate_on <= r;
    len_on <= l;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    do begin
      @(negedge pclk);
      n++;
    end while (cfg_ready !== 1'h1 && n < 20);
    cmp("cfg_ready", 32'h1, {31'h0, cfg_ready});
    @(posedge pclk);
  endtask

  task automatic check_cfg(logic [3:0] a, logic b, logic r, logic l);
    logic [7:0] sa;
    sa = (b ? 8'h50 : 8'h40) + {4'h0, a};
    cmp("rate_hi", {31'h0, r}, {31'h0, rate_hi});
    cmp("payload_len", (r && l) ? 32'h20 : 32'h11, {26'h0, payload_len});
    cmp("station_addr", {24'h0, sa}, {24'h0, station_addr});
    cmp("addr_valid", {31'h0, sa != 8'h40}, {31'h0, addr_valid});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_factory();
    restart(4'h1, 1'h0, 1'h1, 1'h1);
    check_cfg(4'h1, 1'h0, 1'h1, 1'h1);
  endtask

  task automatic t_table();
    for (int i = 0; i < 32; i++) begin
      restart(i[3:0], i[4], i[0], i[1]);
      check_cfg(i[3:0], i[4], i[0], i[1]);
    end
  endtask

  // switches moved in service must not reach the outputs until a restart
  task automatic t_hold();
    restart(4'h3, 1'h1, 1'h1, 1'h0);
    addr_set <= 4'hc;
    base_hi <= 1'h0;
    rate_on <= 1'h0;
    repeat (10) @(posedge pclk);
    check_cfg(4'h3, 1'h1, 1'h1, 1'h0);
    apb(1'h0, 8'h00);
    cmp("addr word", 32'h153, rd);
    apb(1'h0, 8'h04);
    cmp("cfg word", 32'hd1, rd);
    apb(1'h0, 8'h08);
    cmp("latched pins", 32'h53, rd);
    apb(1'h0, 8'h0c);
    cmp("live pins", 32'h0c, rd);
    apb(1'h0, 8'h10);
    cmp("unmapped refused", 32'h1, {31'h0, err});
    apb(1'h1, 8'h00);
    cmp("write refused", 32'h1, {31'h0, err});
    apb(1'h0, 8'h00);
    cmp("addr word kept", 32'h153, rd);
    legacy_net <= 1'h1;
    restart(4'hc, 1'h0, 1'h1, 1'h1);
    check_cfg(4'hc, 1'h0, 1'h0, 1'h0);
  endtask

  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  // whole run is about 320 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'hffff_ffff;
    legacy_net = 1'h0;
    t_factory();
    t_table();
    t_hold();
    end_sim();
  end
endmodule
